// ==== common/quad_dac_cfg.svh ====
`ifndef QUAD_DAC_CFG_SVH
`define QUAD_DAC_CFG_SVH

// Serial frame layout, shared with the host side
`define FRAME_W 24
`define PKG_ID_MSB 23
`define PKG_ID_LSB 19
`define CHAN_MSB 18
`define CHAN_LSB 17
`define CODE_MSB 13
`define CODE_LSB 0
`define NUM_CHAN 4

// Register byte offsets
`define CONTROL_OFS 8'h00
`define STATUS_OFS 8'h04
`define INPUT_OFS 8'h10
`define LATCH_OFS 8'h20
`define CHAN_OFS_MASK 8'hf3

// Reset values
`define CONTROL_RST 1'b1
`define CODE_RST 14'h0000
`define COUNT_RST 8'h00

`endif

// ==== common/quad_dac_pkg.sv ====
`default_nettype none
`include "quad_dac_cfg.svh"

package quad_dac_pkg;
   typedef logic [`FRAME_W-1:0] frame_t;
   typedef logic [`CODE_MSB-`CODE_LSB:0] dac_code_t;
   typedef logic [`CHAN_MSB-`CHAN_LSB:0] chan_t;
   typedef logic [`PKG_ID_MSB-`PKG_ID_LSB:0] pkg_id_t;
   typedef enum logic [1:0] {OUT_GROUND = 2'b01, OUT_LIVE = 2'b10} out_mode_t;
endpackage

`default_nettype wire

// ==== common/serial_frame_if.sv ====
`default_nettype none

interface serial_frame_if;
   import quad_dac_pkg::*;
   logic frame_valid;
   frame_t frame_word;
   modport rx (output frame_valid, output frame_word);
   modport core (input frame_valid, input frame_word);
endinterface

`default_nettype wire

// ==== core/frame_receiver.sv ====
`default_nettype none
`include "quad_dac_cfg.svh"

module frame_receiver (
   // System
   input wire logic hclk,
   input wire logic hresetn,
   // Serial pins
   input wire logic sclk,
   input wire logic sdin,
   input wire logic frame_sync_n,
   // Completed frames
   serial_frame_if.rx frame
);
   import quad_dac_pkg::*;

   logic [2:0] meta;
   logic [2:0] sync;
   logic sclk_d;
   logic fs_d;
   frame_t shift;
   logic sclk_fall;
   logic fs_rise;

   // Clock, data and sync share one latency, so data is aligned to its edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta <= 3'h5;
         sync <= 3'h5;
      end
      else
      begin
         meta <= {sclk, sdin, frame_sync_n};
         sync <= meta;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sclk_d <= 1'b1;
         fs_d <= 1'b1;
      end
      else
      begin
         sclk_d <= sync[2];
         fs_d <= sync[0];
      end
   end

   assign sclk_fall = sclk_d & ~sync[2];
   assign fs_rise = ~fs_d & sync[0];

   // Edges outside a frame are ignored
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         shift <= '0;
      else if (!sync[0] && sclk_fall)
         shift <= {shift[`FRAME_W-2:0], sync[1]};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         frame.frame_valid <= 1'b0;
         frame.frame_word <= '0;
      end
      else
      begin
         frame.frame_valid <= fs_rise;
         if (fs_rise)
            frame.frame_word <= shift;
      end
   end

   shift_on_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!sync[0] && sclk_fall) |=> (shift[0] == $past(sync[1])) && (shift[`FRAME_W-1:1] == $past(shift[`FRAME_W-2:0])))
      else $error("serial bit not shifted on clock fall");

   frame_on_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fs_rise |=> frame.frame_valid && (frame.frame_word == $past(shift)) ##1 !frame.frame_valid)
      else $error("frame not delivered on sync rise");
endmodule

`default_nettype wire

// ==== core/quad_dac_serial_load_control.sv ====
`default_nettype none
`include "quad_dac_cfg.svh"

module quad_dac_serial_load_control #(
   parameter int NUM_CHAN = `NUM_CHAN
) (
   // System
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Serial link pins
   input wire logic sclk,
   input wire logic sdin,
   input wire logic frame_sync_n,
   // Control pins
   input wire logic latch_update_n,
   input wire logic force_ground_level_n,
   input wire logic package_match_enable,
   input wire logic [4:0] package_id_straps,
   // Converter side
   output quad_dac_pkg::dac_code_t dac_level [NUM_CHAN],
   output logic outputs_grounded
);
   import quad_dac_pkg::*;

   localparam int CODE_W = $bits(dac_code_t);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   serial_frame_if frame_bus ();

   frame_receiver u_rx (
      .hclk(hclk),
      .hresetn(hresetn),
      .sclk(sclk),
      .sdin(sdin),
      .frame_sync_n(frame_sync_n),
      .frame(frame_bus.rx)
   );

   logic [6:0] pin_meta;
   logic [6:0] pin_sync;
   logic load_low;
   logic match_en;
   pkg_id_t straps;
   logic clear_rel0;
   logic clear_active;
   out_mode_t mode;
   logic control;
   logic next_control;
   logic [7:0] accept_cnt;
   logic [7:0] reject_cnt;
   logic accept;
   pkg_id_t frame_id;
   chan_t frame_chan;
   dac_code_t frame_code;
   dac_code_t input_reg [NUM_CHAN];
   dac_code_t latch [NUM_CHAN];
   logic [NUM_CHAN*CODE_W-1:0] input_flat;
   logic [NUM_CHAN*CODE_W-1:0] latch_flat;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic rd_take;
   logic [31:0] read_word;

   // Frame goes ahead if broadcast or id matches
   function automatic logic frame_accepted(input pkg_id_t id, input logic bcast, input pkg_id_t own);
      frame_accepted = bcast | (id == own);
   endfunction

   // Straps are static but still synchronised: nothing guarantees that at reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_meta <= 7'h40;
         pin_sync <= 7'h40;
      end
      else
      begin
         pin_meta <= {latch_update_n, package_match_enable, package_id_straps};
         pin_sync <= pin_meta;
      end
   end

   assign load_low = ~pin_sync[6];
   assign match_en = pin_sync[5];
   assign straps = pin_sync[4:0];

   // Clear asserts at once and releases two edges after the pin rises
   always_ff @(posedge hclk or negedge hresetn or negedge force_ground_level_n)
   begin
      if (!hresetn)
      begin
         clear_rel0 <= 1'b1;
         clear_active <= 1'b1;
      end
      else if (!force_ground_level_n)
      begin
         clear_rel0 <= 1'b1;
         clear_active <= 1'b1;
      end
      else
      begin
         clear_rel0 <= 1'b0;
         clear_active <= clear_rel0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn or negedge force_ground_level_n)
   begin
      if (!hresetn)
         mode <= OUT_GROUND;
      else if (!force_ground_level_n)
         mode <= OUT_GROUND;
      else
      begin
         unique case (mode)
            OUT_GROUND:
               if (load_low && !clear_active)
                  mode <= OUT_LIVE;
            OUT_LIVE:
               mode <= OUT_LIVE;
            default:
               mode <= OUT_GROUND;
         endcase
      end
   end

   assign outputs_grounded = (mode != OUT_LIVE);

   assign frame_id = frame_bus.frame_word[`PKG_ID_MSB:`PKG_ID_LSB];
   assign frame_chan = frame_bus.frame_word[`CHAN_MSB:`CHAN_LSB];
   assign frame_code = frame_bus.frame_word[`CODE_MSB:`CODE_LSB];
   assign accept = frame_bus.frame_valid & control & frame_accepted(frame_id, match_en, straps);

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1)
      begin : g_chan
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               input_reg[ch] <= `CODE_RST;
            else if (accept && frame_chan == chan_t'(ch))
               input_reg[ch] <= frame_code;
         end

         // Transparent while load is low; frozen while high or clearing
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               latch[ch] <= `CODE_RST;
            else if (load_low && !clear_active)
               latch[ch] <= input_reg[ch];
         end

         assign dac_level[ch] = latch[ch];
         assign input_flat[ch*CODE_W +: CODE_W] = input_reg[ch];
         assign latch_flat[ch*CODE_W +: CODE_W] = latch[ch];
      end
   endgenerate

   // Counters wrap; software takes differences
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         accept_cnt <= `COUNT_RST;
         reject_cnt <= `COUNT_RST;
      end
      else if (frame_bus.frame_valid)
      begin
         if (accept)
            accept_cnt <= accept_cnt + 8'h01;
         else
            reject_cnt <= reject_cnt + 8'h01;
      end
   end

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rd_take = hsel & hready & htrans[1] & ~hwrite;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= hsel & hready & htrans[1] & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   assign next_control = (wr_pend && wr_addr == `CONTROL_OFS) ? hwdata[0] : control;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         control <= `CONTROL_RST;
      else
         control <= next_control;
   end

   // Read mux sees a write in its data phase, so back-to-back read is current
   always_comb
   begin
      read_word = 32'h0;
      if (haddr[7:0] == `CONTROL_OFS)
         read_word = {31'h0, next_control};
      else if (haddr[7:0] == `STATUS_OFS)
         read_word = {8'h0, reject_cnt, accept_cnt, 5'h0, load_low, clear_active, outputs_grounded};
      else if ((haddr[7:0] & `CHAN_OFS_MASK) == `INPUT_OFS)
         read_word = 32'(input_reg[haddr[3:2]]);
      else if ((haddr[7:0] & `CHAN_OFS_MASK) == `LATCH_OFS)
         read_word = 32'(latch[haddr[3:2]]);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (rd_take)
         hrdata <= read_word;
   end

   pkg_match_a: assert property (
      (frame_bus.frame_valid && control && !match_en && frame_id == straps)
      |=> input_reg[$past(frame_chan)] == $past(frame_code))
      else $error("matching frame not written");

   broadcast_a: assert property (
      (frame_bus.frame_valid && control && match_en) |=> input_reg[$past(frame_chan)] == $past(frame_code))
      else $error("broadcast frame not written");

   mismatch_drop_a: assert property (
      (frame_bus.frame_valid && !match_en && frame_id != straps) |=> $stable(input_flat) && $changed(reject_cnt))
      else $error("mismatching frame not discarded");

   hold_latch_a: assert property (
      !load_low |=> $stable(latch_flat))
      else $error("latch moved while load high");

   load_copy_a: assert property (
      (load_low && !clear_active) |=> latch_flat == $past(input_flat))
      else $error("load low did not copy input registers");

   clear_ground_a: assert property (
      !force_ground_level_n |-> outputs_grounded && clear_active)
      else $error("clear did not ground outputs");

   stay_ground_a: assert property (
      (outputs_grounded && !(load_low && !clear_active)) |=> outputs_grounded)
      else $error("outputs left ground without load");

   live_return_a: assert property (
      (outputs_grounded && load_low && !clear_active) ##1 force_ground_level_n |-> !outputs_grounded)
      else $error("outputs not restored by load");

   clear_ignores_a: assert property (
      clear_active |=> outputs_grounded && $stable(latch_flat))
      else $error("load acted during clear");
endmodule

`default_nettype wire

// ==== verif/quad_dac_serial_load_control_bench.sv ====
`default_nettype none
`include "quad_dac_cfg.svh"

module quad_dac_serial_load_control_bench;
   import quad_dac_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam pkg_id_t STRAP = 5'h0b;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic sclk, sdin, frame_sync_n, load_n, clear_n, match_en, grounded;
   dac_code_t dac_level [4];
   dac_code_t exp_code [4];
   int err_total = 0;
   int samples_checked = 0;

   assign hready = hreadyout;

   quad_dac_serial_load_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .sdin(sdin),
      .frame_sync_n(frame_sync_n), .latch_update_n(load_n), .force_ground_level_n(clear_n),
      .package_match_enable(match_en), .package_id_straps(STRAP), .dac_level(dac_level),
      .outputs_grounded(grounded));

   serial_host host (.sclk(sclk), .sdin(sdin), .frame_sync_n(frame_sync_n));

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic report_and_stop();
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_check(input string what, input logic [31:0] a, input logic [31:0] exp);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b0;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      do @(posedge hclk); while (hready !== 1'b1);
      check(what, hrdata, exp);
      check("hresp", 32'(hresp), 32'h0);
   endtask

   task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask

   // Layout comes from the shared header, never from literals here
   task automatic frame(input pkg_id_t id, input int ch, input dac_code_t code);
      frame_t w;
      w = '0;
      w[`PKG_ID_MSB:`PKG_ID_LSB] = id;
      w[`CHAN_MSB:`CHAN_LSB] = chan_t'(ch);
      w[`CODE_MSB:`CODE_LSB] = code;
      host.send_frame(w);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic check_inputs();
      for (int i = 0; i < 4; i++)
         reg_check("input", 32'(`INPUT_OFS) + 32'(4 * i), 32'(exp_code[i]));
   endtask

   task automatic check_levels(input string what);
      for (int i = 0; i < 4; i++)
         check(what, 32'(dac_level[i]), 32'(exp_code[i]));
   endtask

   initial
   begin
      #100_000;
      err_total++;
      report_and_stop();
   end

   initial
   begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      load_n = 1'b1;
      clear_n = 1'b1;
      match_en = 1'b0;
      exp_code = '{default: '0};
      cycles(5);
      hresetn <= 1'b1;
      cycles(3);
      check("grounded", 32'(grounded), 32'h1);
      reg_check("control", 32'(`CONTROL_OFS), 32'h1);
      reg_check("unmapped", 32'h0000_0080, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         exp_code[i] = 14'h3a00 + 14'(i * 'h111);
         frame(STRAP, i, exp_code[i]);
      end
      check_inputs();
      frame(STRAP ^ 5'h01, 1, 14'h1555);
      reg_check("input1", 32'(`INPUT_OFS) + 32'h4, 32'(exp_code[1]));
      reg_write(32'(`CONTROL_OFS), 32'h0);
      reg_check("control_off", 32'(`CONTROL_OFS), 32'h0);
      frame(STRAP, 0, 14'h0fff);
      reg_check("input0", 32'(`INPUT_OFS), 32'(exp_code[0]));
      reg_write(32'(`CONTROL_OFS), 32'h1);
      reg_check("control_on", 32'(`CONTROL_OFS), 32'h1);
      match_en <= 1'b1;
      exp_code[2] = 14'h2aaa;
      frame(STRAP ^ 5'h10, 2, exp_code[2]);
      reg_check("input2", 32'(`INPUT_OFS) + 32'h8, 32'(exp_code[2]));
      for (int i = 0; i < 4; i++)
         check("level", 32'(dac_level[i]), 32'h0);
      load_n <= 1'b0;
      cycles(8);
      check_levels("latched");
      check("grounded", 32'(grounded), 32'h0);
      load_n <= 1'b1;
      cycles(2);
      frame(STRAP, 3, 14'h0c3c);
      check("level3", 32'(dac_level[3]), 32'(exp_code[3]));
      @(posedge hclk);
      clear_n <= 1'b0;
      #1;
      check("cleared", 32'(grounded), 32'h1);
      @(posedge hclk);
      load_n <= 1'b0;
      cycles(8);
      check("level3", 32'(dac_level[3]), 32'(exp_code[3]));
      check("cleared", 32'(grounded), 32'h1);
      load_n <= 1'b1;
      cycles(2);
      clear_n <= 1'b1;
      cycles(8);
      check("held", 32'(grounded), 32'h1);
      exp_code[3] = 14'h0c3c;
      load_n <= 1'b0;
      cycles(8);
      check("restored", 32'(grounded), 32'h0);
      check_levels("restored");
      reg_check("latch3", 32'(`LATCH_OFS) + 32'hc, 32'h0c3c);
      // Six frames taken, one id mismatch and one refused while disabled
      reg_check("status", 32'(`STATUS_OFS), 32'h0002_0604);
      report_and_stop();
   end
endmodule

`default_nettype wire

// ==== verif/serial_host.sv ====
`default_nettype none
`include "quad_dac_cfg.svh"

module serial_host (
   // Serial link pins
   output logic sclk,
   output logic sdin,
   output logic frame_sync_n
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      sclk = 1'b1;
      sdin = 1'b0;
      frame_sync_n = 1'b1;
   end

   // Clock stands still high outside frames
   task automatic send_frame(input logic [`FRAME_W-1:0] w);
      frame_sync_n <= 1'b0;
      #80;
      for (int i = `FRAME_W - 1; i >= 0; i--)
      begin
         sdin <= w[i];
         #40 sclk <= 1'b0;
         #40 sclk <= 1'b1;
      end
      #40 frame_sync_n <= 1'b1;
      // Released line must not keep showing the last bit
      sdin <= ~sdin;
      #80;
   endtask
endmodule

`default_nettype wire
